/* File: core_clock_model.sv */
// Model of the peripheral core: its clock as ticks and its status word.
// Assumes the bench names the next status value on i_next.
`timescale 1ns/1ps
`default_nettype none
module core_clock_model (
	input  wire logic        i_clock, // Bus clock
	input  wire logic        i_slow,  // Core at half rate
	input  wire logic [15:0] i_next,  // Next core value
	output logic             o_tick,  // Core clock edge
	output logic      [15:0] o_value  // Core status word
);
	logic phase_q = 1'b0;
	// Ticks never stop, even at the bus rate
	always @(posedge i_clock) begin
		phase_q <= !phase_q;
		o_tick  <= !i_slow || phase_q;
		if (o_tick)
			o_value <= i_next;
	end
	initial o_value = 16'h0;
	initial o_tick = 1'b0;
endmodule : core_clock_model
`default_nettype wire

/* File: dist_sync.sv */
// Distributed register synchronizer: bus-side register file with one
// independent synchronization channel per core register.
// Assumes the core clock is seen as a one-cycle tick on i_core_tick and all
// inputs are synchronous to i_clock.
//
// Summary of operation
// - Core register write launches its synchronization
// - Each core register owns a pending busy bit
// - Write to busy register dropped, error raised
// - Registers synchronize independently; only a pending soft reset blocks the others
// - Second byte of busy 16-bit register rejected
// - Word write starts every covered register separately
// - Bus-side registers accessed directly, no delay
// - Synchronization always runs, whatever the clocks
// - Core value change resynchronized with busy bit
// - Read-synced register read returns held value
// - Ready flag set when the reg_a, reg_b, reg_c and read busy bits all clear
// - Enable write syncs, reads back new value
// - Enable completion never raises ready flag
// - Soft reset write one syncs, both clear later
// - Writing zero to soft reset does nothing
// - Soft reset completion never raises ready flag
// - Latency between five and six core periods, then two bus cycles
// - Masked interface reads zero, drops writes
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module dist_sync #(
	parameter int CORE_TICKS = dist_sync_pkg::SYNC_CORE_TICKS,
	parameter int BUS_CYCLES = dist_sync_pkg::SYNC_BUS_CYCLES
) (
	input  wire logic                      i_clock,      // Bus clock
	input  wire logic                      i_rst,        // Sync reset, high
	input  wire logic [7:0]                i_addr,       // Byte address
	input  wire logic [31:0]               i_wdata,      // Write data
	input  wire logic [3:0]                i_byte_en,    // Write byte lanes
	input  wire logic                      i_write,      // Write strobe
	input  wire logic                      i_read,       // Read strobe
	output logic      [31:0]               o_rdata,      // Read data, +1
	input  wire logic                      i_bus_masked, // Interface masked
	input  wire logic                      i_core_tick,  // Core clock edge
	input  wire logic [15:0]               i_core_value, // Core status word
	output dist_sync_pkg::core_regs_t      o_core,       // Core-side regs
	output logic                           o_core_reset, // Core reset pulse
	output logic                           o_irq         // Interrupt level
);

	localparam int NCH = dist_sync_pkg::NUM_CH;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (CORE_TICKS < 1 || CORE_TICKS > 7) begin : g_bad_ticks
		$error("CORE_TICKS must lie in 1..7");
	end
	if (BUS_CYCLES < 1 || BUS_CYCLES > 3) begin : g_bad_bus
		$error("BUS_CYCLES must lie in 1..3");
	end

	localparam logic [2:0] TICK_LAST = 3'(CORE_TICKS - 1);
	localparam logic [1:0] TAIL_LOAD = 2'(BUS_CYCLES);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                     ctrl_enable;
		logic                     ctrl_swrst;
		logic [7:0]               shadow_a;
		logic [7:0]               shadow_b;
		logic [15:0]              shadow_c;
		dist_sync_pkg::core_regs_t core;
		logic                     core_reset;
		logic [NCH-1:0]           busy;
		logic [NCH-1:0][2:0]      ticks;
		logic [NCH-1:0][1:0]      tail;
		logic [15:0]              capture;
		logic [15:0]              held;
		logic [1:0]               flags;
		logic [1:0]               mask;
		logic [31:0]              scratch;
		logic [31:0]              rdata;
		logic                     irq;
		logic                     seen;
	} state_t;

	state_t q;
	state_t d;

	assign o_rdata      = q.rdata;
	assign o_core       = q.core;
	assign o_core_reset = q.core_reset;
	assign o_irq        = q.irq;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [NCH-1:0] done;
		logic [NCH-1:0] start;
		logic           wr;
		logic           rd;
		logic           err;
		logic [31:0]    rword;
		done  = '0;
		start = '0;
		err   = 1'b0;
		rword = 32'h0000_0000;
		wr    = i_write & ~i_bus_masked;
		rd    = i_read & ~i_bus_masked;
		d     = q;
		d.core_reset = 1'b0;
		d.rdata      = 32'h0000_0000;

		// Channel timers: count core ticks, then a short bus-side tail.
		// Running on every bus clock regardless of clock relation.
		for (int i = 0; i < NCH; i++) begin
			if (q.busy[i]) begin
				if (q.tail[i] != 2'h0) begin
					d.tail[i] = q.tail[i] - 2'h1;
					done[i]   = (q.tail[i] == 2'h1);
				end else if (i_core_tick) begin
					d.ticks[i] = q.ticks[i] + 3'h1;
					if (q.ticks[i] == TICK_LAST) begin
						d.tail[i] = TAIL_LOAD;
					end
				end
			end
			if (done[i]) begin
				d.busy[i] = 1'b0;
			end
		end

		// Commit of finished channels: write channels into the core side, the read channel into held
		if (done[dist_sync_pkg::CH_REG_A]) begin
			d.core.reg_a = q.shadow_a;
		end
		if (done[dist_sync_pkg::CH_REG_B]) begin
			d.core.reg_b = q.shadow_b;
		end
		if (done[dist_sync_pkg::CH_REG_C]) begin
			d.core.reg_c = q.shadow_c;
		end
		if (done[dist_sync_pkg::CH_ENABLE]) begin
			d.core.enable = q.ctrl_enable;
		end
		if (done[dist_sync_pkg::CH_READ]) begin
			d.held = q.capture;
		end

		// Core value changed: carry it toward the bus side
		if (!q.busy[dist_sync_pkg::CH_READ] && !q.ctrl_swrst &&
		    i_core_value != q.held) begin
			d.capture = i_core_value;
			start[dist_sync_pkg::CH_READ] = 1'b1;
		end

		// Register writes; while a soft reset is pending all are dropped
		if (wr && !q.ctrl_swrst) begin
			case (i_addr)
				dist_sync_pkg::OFS_CTRL: begin
					if (i_byte_en[0]) begin
						if (q.busy[dist_sync_pkg::CH_ENABLE]) begin
							err = 1'b1;
						end else begin
							d.ctrl_enable =
								i_wdata[dist_sync_pkg::CTRL_ENABLE_POS];
							start[dist_sync_pkg::CH_ENABLE] = 1'b1;
						end
						// A zero in the reset bit is simply not acted on
						if (i_wdata[dist_sync_pkg::CTRL_SOFT_RESET_POS]) begin
							d.ctrl_swrst = 1'b1;
							start[dist_sync_pkg::CH_SOFT_RESET] = 1'b1;
						end
					end
				end
				dist_sync_pkg::OFS_CORE_REGS: begin
					// Each register checks its own busy bit only
					if (i_byte_en[0]) begin
						if (q.busy[dist_sync_pkg::CH_REG_A]) begin
							err = 1'b1;
						end else begin
							d.shadow_a = i_wdata[7:0];
							start[dist_sync_pkg::CH_REG_A] = 1'b1;
						end
					end
					if (i_byte_en[1]) begin
						if (q.busy[dist_sync_pkg::CH_REG_B]) begin
							err = 1'b1;
						end else begin
							d.shadow_b = i_wdata[15:8];
							start[dist_sync_pkg::CH_REG_B] = 1'b1;
						end
					end
					if (i_byte_en[2] || i_byte_en[3]) begin
						if (q.busy[dist_sync_pkg::CH_REG_C]) begin
							err = 1'b1;
						end else begin
							if (i_byte_en[2]) begin
								d.shadow_c[7:0] = i_wdata[23:16];
							end
							if (i_byte_en[3]) begin
								d.shadow_c[15:8] = i_wdata[31:24];
							end
							start[dist_sync_pkg::CH_REG_C] = 1'b1;
						end
					end
				end
				dist_sync_pkg::OFS_INT_FLAG: begin
					if (i_byte_en[0]) begin
						d.flags = q.flags & ~i_wdata[1:0];
					end
				end
				dist_sync_pkg::OFS_INT_MASK: begin
					if (i_byte_en[0]) begin
						d.mask = i_wdata[1:0];
					end
				end
				dist_sync_pkg::OFS_SCRATCH: begin
					for (int b = 0; b < 4; b++) begin
						if (i_byte_en[b]) begin
							d.scratch[b*8 +: 8] = i_wdata[b*8 +: 8];
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Launch channels
		for (int i = 0; i < NCH; i++) begin
			if (start[i]) begin
				d.busy[i]  = 1'b1;
				d.ticks[i] = 3'h0;
				d.tail[i]  = 2'h0;
			end
		end
		if (start[NCH-1:dist_sync_pkg::CH_REG_A] != '0) begin
			d.seen = 1'b1;
		end

		// Soft reset finished: all state but the read data returns to its reset value, and core reset pulses
		if (done[dist_sync_pkg::CH_SOFT_RESET]) begin
			d.ctrl_enable = 1'b0;
			d.ctrl_swrst  = 1'b0;
			d.shadow_a    = 8'h00;
			d.shadow_b    = 8'h00;
			d.shadow_c    = 16'h0000;
			d.core        = '0;
			d.core_reset  = 1'b1;
			d.busy        = '0;
			d.ticks       = '0;
			d.tail        = '0;
			d.capture     = 16'h0000;
			d.held        = 16'h0000;
			d.mask        = dist_sync_pkg::RST_FLAG;
			d.flags       = dist_sync_pkg::RST_FLAG;
			d.scratch     = dist_sync_pkg::RST_WORD;
			d.seen        = 1'b0;
		end else begin
			// Only data channels arm the ready flag, so enable and reset
			// completions alone never raise it. Set wins over clear.
			if (q.seen && d.busy[NCH-1:dist_sync_pkg::CH_REG_A] == '0) begin
				d.flags[dist_sync_pkg::FLAG_READY_POS] = 1'b1;
				d.seen = 1'b0;
			end
			if (err) begin
				d.flags[dist_sync_pkg::FLAG_ERROR_POS] = 1'b1;
			end
		end

		// Read mux, answered in the next cycle without wait
		case (i_addr)
			dist_sync_pkg::OFS_CTRL: begin
				rword[dist_sync_pkg::CTRL_ENABLE_POS] = q.ctrl_enable;
				rword[dist_sync_pkg::CTRL_SOFT_RESET_POS] = q.ctrl_swrst;
			end
			dist_sync_pkg::OFS_CORE_REGS: begin
				rword = {q.shadow_c, q.shadow_b, q.shadow_a};
			end
			dist_sync_pkg::OFS_PENDING: begin
				rword[NCH-1:0] = q.busy;
			end
			dist_sync_pkg::OFS_INT_FLAG: begin
				rword[1:0] = q.flags;
			end
			dist_sync_pkg::OFS_INT_MASK: begin
				rword[1:0] = q.mask;
			end
			dist_sync_pkg::OFS_SCRATCH: begin
				rword = q.scratch;
			end
			dist_sync_pkg::OFS_CORE_READ: begin
				rword[15:0] = q.held;
			end
			default: begin
				rword = 32'h0000_0000;
			end
		endcase
		if (rd) begin
			d.rdata = rword;
		end

		d.irq = |(d.flags & d.mask);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : dist_sync

`default_nettype wire

/* File: dist_sync_asserts.sv */
// Checker for the distributed register synchronizer, port level only.
// Assumes a core tick at most once per bus cycle.
`timescale 1ns/1ps
`default_nettype none
module dist_sync_asserts #(
	parameter int CORE_TICKS = 6
) (
	input wire logic                      i_clock,
	input wire logic                      i_rst,
	input wire logic [7:0]                i_addr,
	input wire logic [31:0]               i_wdata,
	input wire logic [3:0]                i_byte_en,
	input wire logic                      i_write,
	input wire logic                      i_read,
	input wire logic [31:0]               o_rdata,
	input wire logic                      i_bus_masked,
	input wire logic                      i_core_tick,
	input wire logic [15:0]               i_core_value,
	input wire dist_sync_pkg::core_regs_t o_core,
	input wire logic                      o_core_reset,
	input wire logic                      o_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic wr_a;
	assign wr_a = i_write && !i_bus_masked && i_byte_en[0]
		&& i_addr == dist_sync_pkg::OFS_CORE_REGS;
	rdata_idle_a: assert property (!i_read |=> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	mask_read_a: assert property (i_read && i_bus_masked |=> o_rdata == 0)
		else $error("masked read returned data");
	unmapped_rd_a: assert property (i_read && i_addr == 8'h1c |=> !o_rdata)
		else $error("unmapped read returned data");
	reset_pulse_a: assert property (o_core_reset |=> !o_core_reset)
		else $error("core reset longer than one cycle");
	reset_clear_a: assert property (o_core_reset |=> o_core == '0)
		else $error("core registers kept after soft reset");
	reset_irq_a: assert property (o_core_reset |=> !o_irq)
		else $error("interrupt after soft reset");
	// Core side may not see the value before the tick count has run
	sync_delay_a: assert property (wr_a |=> $stable(o_core.reg_a) [*7])
		else $error("core register updated too early");
	irq_mask_a: assert property (i_write && !i_bus_masked && i_byte_en[0]
		&& i_addr == dist_sync_pkg::OFS_INT_MASK && i_wdata[1:0] == 2'h0
		|=> ##1 !o_irq)
		else $error("masked interrupt still raised");
endmodule : dist_sync_asserts
bind dist_sync dist_sync_asserts #(.CORE_TICKS(CORE_TICKS)) u_chk (
	.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_byte_en(i_byte_en), .i_write(i_write), .i_read(i_read),
	.o_rdata(o_rdata), .i_bus_masked(i_bus_masked),
	.i_core_tick(i_core_tick), .i_core_value(i_core_value),
	.o_core(o_core), .o_core_reset(o_core_reset), .o_irq(o_irq));
`default_nettype wire

/* File: dist_sync_pkg.sv */
// Constants, register map and carrier types for the distributed register
// synchronizer. Assumes a 32-bit byte-addressed register port.
package dist_sync_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_CORE_REGS = 8'h04;
	localparam logic [7:0] OFS_PENDING   = 8'h08;
	localparam logic [7:0] OFS_INT_FLAG  = 8'h0c;
	localparam logic [7:0] OFS_INT_MASK  = 8'h10;
	localparam logic [7:0] OFS_SCRATCH   = 8'h14;
	localparam logic [7:0] OFS_CORE_READ = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_SOFT_RESET_POS = 0;
	localparam int CTRL_ENABLE_POS     = 1;
	localparam int FLAG_READY_POS      = 0;
	localparam int FLAG_ERROR_POS      = 1;

	// Channel indices, also the bit positions of pending_sync_mask
	localparam int CH_SOFT_RESET = 0;
	localparam int CH_ENABLE     = 1;
	localparam int CH_REG_A      = 2;
	localparam int CH_REG_B      = 3;
	localparam int CH_REG_C      = 4;
	localparam int CH_READ       = 5;
	localparam int NUM_CH        = 6;

	// ----------------------------------------------------------------
	// Timing: core ticks waited, then bus cycles of hand-back
	// ----------------------------------------------------------------
	localparam int SYNC_CORE_TICKS = 6;
	localparam int SYNC_BUS_CYCLES = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0]  RST_FLAG = 2'h0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] reg_c;
		logic [7:0]  reg_b;
		logic [7:0]  reg_a;
		logic        enable;
	} core_regs_t;

endpackage : dist_sync_pkg

/* File: distributed_register_sync_test.sv */
// Self-checking bench for the distributed register synchronizer.
// Assumes the core clock model drives the tick and status word.
`timescale 1ns/1ps
`default_nettype none
module distributed_register_sync_test;
	logic i_clock = 0, i_rst = 1, i_write = 0, i_read = 0, i_bus_masked = 0;
	logic [7:0] i_addr = 0;
	logic [31:0] i_wdata = 0, o_rdata, sd, w;
	logic [3:0] i_byte_en = 0;
	logic slow = 0, tick, rd_d = 0, o_core_reset, o_irq;
	logic [15:0] nxt = 0, cval;
	logic [7:0] a, b;
	dist_sync_pkg::core_regs_t o_core;
	logic [32:0] exp_q[$];
	int fails = 0, cmp_count = 0, cyc = 0, seed = 32'h00eee31a;
	dist_sync u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_byte_en(i_byte_en), .i_write(i_write),
		.i_read(i_read), .o_rdata(o_rdata), .i_bus_masked(i_bus_masked),
		.i_core_tick(tick), .i_core_value(cval), .o_core(o_core),
		.o_core_reset(o_core_reset), .o_irq(o_irq));
	core_clock_model u_core (.i_clock(i_clock), .i_slow(slow), .i_next(nxt),
		.o_tick(tick), .o_value(cval));
	initial forever #50 i_clock = !i_clock;
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge i_clock);
		i_addr <= ad; i_wdata <= d; i_byte_en <= be;
		i_write <= 1; i_read <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		@(posedge i_clock);
		i_addr <= ad; i_read <= 1; i_write <= 0;
		exp_q.push_back({1'b0, e});
	endtask : rd
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge i_clock);
			i_write <= 0; i_read <= 0;
		end
	endtask : idle
	// ----------------------------------------------------------------
	// Monitor: read data stand only in the cycle after the strobe
	// ----------------------------------------------------------------
	always @(posedge i_clock) rd_d <= i_read;
	always @(negedge i_clock) if (rd_d) chk({1'b0, o_rdata}, exp_q.pop_front());
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge i_clock);
		i_rst <= 0;
		sd = $random(seed); a = $random(seed); b = $random(seed);
		rd(dist_sync_pkg::OFS_CTRL, 0);
		rd(dist_sync_pkg::OFS_PENDING, 0);
		wr(dist_sync_pkg::OFS_INT_MASK, 3, 4'hf);
		wr(dist_sync_pkg::OFS_SCRATCH, sd, 4'hf);
		rd(dist_sync_pkg::OFS_SCRATCH, sd);
		idle(1);
		i_bus_masked <= 1;
		wr(dist_sync_pkg::OFS_SCRATCH, ~sd, 4'hf);
		rd(dist_sync_pkg::OFS_SCRATCH, 0);
		idle(1);
		i_bus_masked <= 0;
		rd(dist_sync_pkg::OFS_SCRATCH, sd);
		wr(dist_sync_pkg::OFS_CORE_REGS, {24'h0, a}, 4'h1);
		wr(dist_sync_pkg::OFS_CORE_REGS, {16'h0, b, 8'h0}, 4'h2);
		wr(dist_sync_pkg::OFS_CORE_REGS, {16'h0, ~b, 8'h0}, 4'h2);
		wr(dist_sync_pkg::OFS_CORE_REGS, {8'h0, a, 16'h0}, 4'h4);
		wr(dist_sync_pkg::OFS_CORE_REGS, {b, 24'h0}, 4'h8);
		rd(dist_sync_pkg::OFS_PENDING, 32'h1c);
		rd(dist_sync_pkg::OFS_INT_FLAG, 2);
		idle(20);
		rd(dist_sync_pkg::OFS_CORE_REGS, {8'h0, a, b, a});
		rd(dist_sync_pkg::OFS_INT_FLAG, 3);
		#1 chk(o_core, {8'h0, a, b, a, 1'b0});
		chk(o_irq, 1);
		wr(dist_sync_pkg::OFS_INT_FLAG, 3, 4'h1);
		idle(2);
		rd(dist_sync_pkg::OFS_INT_FLAG, 0);
		w = $random(seed);
		slow <= 1;
		wr(dist_sync_pkg::OFS_CORE_REGS, w, 4'hf);
		rd(dist_sync_pkg::OFS_PENDING, 32'h1c);
		idle(40);
		rd(dist_sync_pkg::OFS_CORE_REGS, w);
		slow <= 0;
		nxt <= ~cval;
		idle(20);
		rd(dist_sync_pkg::OFS_CORE_READ, {16'h0, nxt});
		rd(dist_sync_pkg::OFS_PENDING, 0);
		wr(dist_sync_pkg::OFS_INT_FLAG, 3, 4'h1);
		wr(dist_sync_pkg::OFS_CTRL, 2, 4'h1);
		rd(dist_sync_pkg::OFS_CTRL, 2);
		rd(dist_sync_pkg::OFS_PENDING, 2);
		idle(20);
		rd(dist_sync_pkg::OFS_INT_FLAG, 0);
		#1 chk(o_core.enable, 1);
		wr(dist_sync_pkg::OFS_CTRL, 2, 4'h1);
		rd(dist_sync_pkg::OFS_PENDING, 2);
		idle(20);
		wr(dist_sync_pkg::OFS_CTRL, 3, 4'h1);
		// Core word back to its reset value, so no read sync follows reset
		nxt <= 16'h0000;
		rd(dist_sync_pkg::OFS_CTRL, 3);
		rd(dist_sync_pkg::OFS_PENDING, 3);
		idle(20);
		rd(dist_sync_pkg::OFS_PENDING, 0);
		rd(dist_sync_pkg::OFS_SCRATCH, 0);
		rd(dist_sync_pkg::OFS_INT_FLAG, 0);
		wr(8'h1c, sd, 4'hf);
		rd(8'h1c, 0);
		idle(3);
		tally_and_finish();
	end
endmodule : distributed_register_sync_test
`default_nettype wire
